// ### design/tfc_device.sv
`timescale 1ns/1ps
// Contract
// [RULE_01] flush writes every pending cache block
// [RULE_02] flush good status only after media writes
// [RULE_03] format writes exactly the addressed track
// [RULE_04] every good sector written with zeros
// [RULE_05] no read-back verify after zero writes
// [RULE_06] old track contents are discarded
// [RULE_07] host puts LBA 0-7 in low byte
// [RULE_08] host puts cylinder in mid/high bytes
// [RULE_09] host puts LBA 8-23 in mid/high
// [RULE_10] host puts head in device head field
// [RULE_11] host puts LBA 24-27 in head field
// [RULE_12] device returns LBA 0-7 in low
// [RULE_13] device returns LBA 8-23 in mid/high
// [RULE_14] device returns LBA 24-27 in head field
// [RULE_15] failure sets err, abort/idnf, clears busy
module tfc_device (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // command block carrier
  tfc_if.device bus,
  // write-cache side: a block enters the cache
  input wire logic cache_wr_i,
  input wire logic [27:0] cache_lba_i,
  output logic cache_full_o,
  // media side: one sector write per accepted request
  output logic media_wr_o,
  output logic [27:0] media_lba_o,
  output logic [7:0] media_data_o,
  input wire logic media_ack_i,
  input wire logic media_bad_i,
  input wire logic media_fault_i
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FLUSH = 4'b0010,
    ST_FMT = 4'b0100,
    ST_DONE = 4'b1000
  } tfc_state_t;

  tfc_state_t st_q, st_d;
  logic [27:0] cache_q [tfc_pkg::CACHE_DEPTH];
  logic [tfc_pkg::CACHE_DEPTH-1:0] cvalid_q;
  logic [tfc_pkg::CACHE_IDX_W-1:0] cptr_q;
  logic [27:0] base_q;
  logic [tfc_pkg::SECT_IDX_W-1:0] sect_q;
  logic lba_mode_q;
  logic fail_q;
  logic idnf_q;
  logic [7:0] sts_q;
  logic [7:0] err_q;
  logic done_q;
  logic [27:0] cur_q;

  // decode the addressed track; lba mode selects by device bit 6
  wire lba_sel = bus.dev_reg[tfc_pkg::DEV_LBA_BIT];
  wire [27:0] lba_in = {bus.dev_reg[3:0], bus.lba_high, bus.lba_mid, bus.lba_low}; // RULE_07
  wire [15:0] cyl_in = {bus.lba_high, bus.lba_mid}; // RULE_08
  wire [3:0] head_in = bus.dev_reg[3:0]; // RULE_10
  wire [27:0] chs_base = {8'h00, cyl_in, head_in} * 28'(tfc_pkg::SECT_PER_TRACK);
  // track start: low lba bits cleared so only the one track is touched
  wire [27:0] lba_base = {lba_in[27:tfc_pkg::SECT_IDX_W], {tfc_pkg::SECT_IDX_W{1'b0}}}; // RULE_03
  wire addr_bad = lba_sel ? (lba_in > tfc_pkg::MAX_LBA) : (cyl_in > tfc_pkg::MAX_CYL);
  wire start = clk_en_i && st_q == ST_IDLE && bus.cmd_valid;
  wire is_flush = bus.cmd_op == tfc_pkg::OP_FLUSH_EXT;
  wire is_fmt = bus.cmd_op == tfc_pkg::OP_FMT_TRACK;
  wire any_pend = |cvalid_q;
  wire ptr_pend = cvalid_q[cptr_q];
  wire last_sect = sect_q == tfc_pkg::SECT_IDX_W'(tfc_pkg::SECT_PER_TRACK - 1);
  wire [27:0] fmt_lba = base_q + 28'(sect_q);
  wire cmd_known = is_flush || is_fmt;

  // a sector leaves the walk when written, or at once when the media marks it bad
  wire fmt_step = st_q == ST_FMT && (media_ack_i || media_bad_i);
  wire fmt_fault = st_q == ST_FMT && media_ack_i && media_fault_i;
  // a faulted write keeps its block pending, so a later flush retries it unless a new cache write first overwrites that slot
  wire flush_clr = st_q == ST_FLUSH && ptr_pend && media_ack_i && !media_fault_i;
  wire flush_skip = st_q == ST_FLUSH && !ptr_pend;
  // blocks are refused during a flush so the walk never chases new entries
  wire cache_take = cache_wr_i && !cache_full_o && st_q != ST_FLUSH;
  // any media fault while a command runs ends it with abort
  wire media_fail = media_ack_i && media_fault_i && st_q != ST_IDLE;

  // completion codes: ready and settled, plus error summary and its cause
  wire [7:0] sts_done = tfc_pkg::STS_RESET | {7'h00, fail_q};
  wire [7:0] err_done = {3'h0, idnf_q, 1'b0, fail_q && !idnf_q, 2'h0};

  // media request: flush pending blocks, or zero sectors of the track
  assign media_wr_o = (st_q == ST_FLUSH && ptr_pend) || (st_q == ST_FMT && !media_bad_i);
  assign media_lba_o = (st_q == ST_FLUSH) ? cache_q[cptr_q] : fmt_lba;
  assign media_data_o = 8'h00; // RULE_04
  assign cache_full_o = &cvalid_q;

  // next state; format ends after the last sector with no verify pass
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        // unknown opcodes and bad format addresses go straight to completion
        if (start && cmd_known) begin
          st_d = (is_fmt && !addr_bad) ? ST_FMT : (is_flush ? ST_FLUSH : ST_DONE);
        end else if (start) begin
          st_d = ST_DONE;
        end
      end
      ST_FLUSH: begin
        if (!any_pend || (media_ack_i && media_fault_i)) begin
          st_d = ST_DONE; // RULE_02
        end
      end
      ST_FMT: begin
        if (fmt_fault || (fmt_step && last_sect)) begin
          st_d = ST_DONE; // RULE_05
        end
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // write cache: new blocks in, flushed blocks out
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cvalid_q <= '0;
      cptr_q <= '0;
    end else if (clk_en_i) begin
      // retire the block under the pointer once its write lands
      for (int i = 0; i < tfc_pkg::CACHE_DEPTH; i++) begin
        if (flush_clr && cptr_q == tfc_pkg::CACHE_IDX_W'(i)) begin
          cvalid_q[i] <= 1'b0; // RULE_01
        end
      end
      if (cache_take) begin
        cvalid_q[cptr_q] <= 1'b1;
        cptr_q <= cptr_q + 1'b1;
      end else if (flush_skip || flush_clr) begin
        cptr_q <= cptr_q + 1'b1; // RULE_01
      end
    end
  end

  // cache address store, no reset needed on data
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && cache_take) begin
      cache_q[cptr_q] <= cache_lba_i;
    end
  end

  // command state, address capture and sector walk
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_IDLE;
      base_q <= '0;
      sect_q <= '0;
      lba_mode_q <= 1'b0;
      fail_q <= 1'b0;
      idnf_q <= 1'b0;
      cur_q <= '0;
    end else if (clk_en_i) begin
      st_q <= st_d;
      if (start) begin
        base_q <= lba_sel ? lba_base : chs_base; // RULE_03
        sect_q <= '0;
        lba_mode_q <= lba_sel;
        fail_q <= !cmd_known || (is_fmt && addr_bad);
        idnf_q <= is_fmt && addr_bad;
        cur_q <= lba_sel ? lba_in : chs_base;
      end else if (media_fail) begin
        fail_q <= 1'b1;
      end else if (fmt_step) begin
        // bad sectors are skipped, good ones overwritten so old data is gone
        if (media_ack_i) begin
          cur_q <= fmt_lba; // RULE_06
        end
        sect_q <= sect_q + 1'b1;
      end
    end
  end

  // status and error registers seen by the host
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sts_q <= tfc_pkg::STS_RESET;
      err_q <= tfc_pkg::ERR_RESET;
      done_q <= 1'b0;
    end else if (clk_en_i) begin
      done_q <= st_q == ST_DONE;
      if (start) begin
        sts_q <= 8'h80;
        err_q <= 8'h00;
      end else if (st_q == ST_DONE) begin
        sts_q <= sts_done; // RULE_15
        err_q <= err_done; // RULE_15
      end
    end
  end

  // current address readback in lba mode
  assign bus.ret_low = lba_mode_q ? cur_q[7:0] : 8'h00; // RULE_12
  assign bus.ret_mid = lba_mode_q ? cur_q[15:8] : 8'h00; // RULE_13
  assign bus.ret_high = lba_mode_q ? cur_q[23:16] : 8'h00; // RULE_13
  assign bus.ret_dev = lba_mode_q ? {4'h4, cur_q[27:24]} : 8'h00; // RULE_14
  assign bus.command_status_flags = sts_q;
  assign bus.command_error_flags = err_q;
  assign bus.done = done_q;
endmodule

// ### pkg/tfc_pkg.sv
package tfc_pkg;
  // opcodes
  localparam logic [7:0] OP_FLUSH_EXT = 8'hEA;
  localparam logic [7:0] OP_FMT_TRACK = 8'h50;
  // device register field positions
  localparam int DEV_LBA_BIT = 6;
  localparam int DEV_HEAD_LSB = 0;
  // error register bit positions
  localparam int ERR_ABT_BIT = 2;
  localparam int ERR_IDN_BIT = 4;
  localparam int ERR_TZM_BIT = 1;
  localparam int ERR_AMM_BIT = 0;
  // status register bit positions
  localparam int STS_BSY_BIT = 7;
  localparam int STS_RDY_BIT = 6;
  localparam int STS_SSF_BIT = 4;
  localparam int STS_ERR_BIT = 0;
  // reset values
  localparam logic [7:0] STS_RESET = 8'h50;
  localparam logic [7:0] ERR_RESET = 8'h00;
  // geometry of the modelled media
  localparam int SECT_PER_TRACK = 16;
  localparam int SECT_IDX_W = 4;
  localparam logic [15:0] MAX_CYL = 16'h03FF;
  localparam logic [27:0] MAX_LBA = 28'h00FFFFF;
  localparam int CACHE_DEPTH = 8;
  localparam int CACHE_IDX_W = 3;
endpackage

// ### pkg/tfc_if.sv
`timescale 1ns/1ps
interface tfc_if;
  logic cmd_valid;
  logic [7:0] cmd_op;
  logic [7:0] lba_low;
  logic [7:0] lba_mid;
  logic [7:0] lba_high;
  logic [7:0] dev_reg;
  logic [7:0] ret_low;
  logic [7:0] ret_mid;
  logic [7:0] ret_high;
  logic [7:0] ret_dev;
  logic [7:0] command_status_flags;
  logic [7:0] command_error_flags;
  logic done;
  modport device (
    input cmd_valid, cmd_op, lba_low, lba_mid, lba_high, dev_reg,
    output ret_low, ret_mid, ret_high, ret_dev, command_status_flags,
    command_error_flags, done
  );
  modport host (
    output cmd_valid, cmd_op, lba_low, lba_mid, lba_high, dev_reg,
    input ret_low, ret_mid, ret_high, ret_dev, command_status_flags,
    command_error_flags, done
  );
endinterface

// ### design/tfc_host.sv
`timescale 1ns/1ps
module tfc_host (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  // user request
  input wire logic req_i,
  input wire logic req_fmt_i,
  input wire logic req_lba_i,
  input wire logic [27:0] req_addr_i,
  input wire logic [15:0] req_cyl_i,
  input wire logic [3:0] req_head_i,
  // user answer
  output logic busy_o,
  output logic done_o,
  output logic [7:0] status_o,
  output logic [7:0] error_o,
  output logic [27:0] cur_lba_o,
  // command block carrier
  tfc_if.host bus
);
  logic busy_q;
  logic done_q;
  logic op_q;
  logic lba_q;
  logic [27:0] addr_q;
  logic [7:0] status_q;
  logic [7:0] error_q;
  logic [27:0] cur_q;

  // command fields; lba or cylinder/head placement
  // valid drops with the device's done pulse, or the idle device would take it again
  assign bus.cmd_valid = busy_q && !done_q && !bus.done;
  assign bus.cmd_op = op_q ? tfc_pkg::OP_FMT_TRACK : tfc_pkg::OP_FLUSH_EXT;
  assign bus.lba_low = addr_q[7:0]; // RULE_07
  assign bus.lba_mid = addr_q[15:8]; // RULE_08 RULE_09
  assign bus.lba_high = addr_q[23:16]; // RULE_08 RULE_09
  assign bus.dev_reg = {1'b1, lba_q, 2'b10, addr_q[27:24]}; // RULE_11
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign status_o = status_q;
  assign error_o = error_q;
  assign cur_lba_o = cur_q;

  // hold the command until the device completes it
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      op_q <= 1'b0;
      lba_q <= 1'b0;
      addr_q <= '0;
      status_q <= '0;
      error_q <= '0;
      cur_q <= '0;
    end else if (clk_en_i) begin
      done_q <= 1'b0;
      if (!busy_q && req_i) begin
        busy_q <= 1'b1;
        op_q <= req_fmt_i;
        lba_q <= req_lba_i;
        addr_q <= req_lba_i ? req_addr_i : {req_head_i, req_cyl_i, 8'h00}; // RULE_08 RULE_10
      end else if (busy_q && !bus.cmd_valid) begin
        busy_q <= 1'b0;
      end
      if (busy_q && bus.done) begin
        done_q <= 1'b1;
        status_q <= bus.command_status_flags;
        error_q <= bus.command_error_flags;
        cur_q <= {bus.ret_dev[3:0], bus.ret_high, bus.ret_mid, bus.ret_low};
      end
    end
  end
endmodule

// ### verification/tfc_props.sv
`timescale 1ns/1ps
module tfc_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // carrier signals
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] lba_low,
  input wire logic [7:0] lba_mid,
  input wire logic [7:0] lba_high,
  input wire logic [7:0] dev_reg,
  input wire logic [7:0] ret_low,
  input wire logic [7:0] ret_mid,
  input wire logic [7:0] ret_high,
  input wire logic [7:0] ret_dev,
  input wire logic [7:0] command_status_flags,
  input wire logic [7:0] command_error_flags,
  input wire logic done
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // address as sent and as returned
  wire [27:0] req_a = {dev_reg[3:0], lba_high, lba_mid, lba_low};
  wire [27:0] ret_a = {ret_dev[3:0], ret_high, ret_mid, ret_low};
  wire bsy = command_status_flags[7];
  wire fail = command_status_flags[0];
  wire fmt_op = cmd_op == tfc_pkg::OP_FMT_TRACK;
  busy_set_a: assert property ($rose(cmd_valid) |-> ##[1:2] bsy)
    else $error("command not taken");
  cmd_hold_a: assert property (cmd_valid && !done |=> done || (cmd_valid && $stable(req_a)))
    else $error("request changed while pending");
  busy_code_a: assert property (bsy && !done |-> command_status_flags == 8'h80)
    else $error("status not plain busy");
  done_idle_a: assert property (done |-> !bsy ##1 !done)
    else $error("busy at completion or long done");
  fail_code_a: assert property (done && fail |-> command_error_flags[2] || command_error_flags[4])
    else $error("failure without cause bit");
  ok_clean_a: assert property (done && !fail |-> command_error_flags == 8'h00)
    else $error("good status with error bits");
  lba_ret_a: assert property (done && fmt_op && dev_reg[6] && !fail |-> ret_a[27:4] == req_a[27:4])
    else $error("returned address off track");
  chs_ret_a: assert property (done && !dev_reg[6] |-> ret_a == 28'h0)
    else $error("readback not zero in chs mode");
  stand_a: assert property (!cmd_valid && !bsy |=> $stable(command_status_flags))
    else $error("status moved while idle");
  // main outcomes
  flush_c: cover property (done && !fmt_op && !fail);
  fmt_c: cover property (done && fmt_op && !fail);
  fail_c: cover property (done && fail);
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic clk_en_i = 1'h1;
  logic req_i = 1'h0, req_fmt_i = 1'h0, req_lba_i = 1'h0;
  logic [27:0] req_addr_i = 28'h0, cache_lba_i = 28'h0, lo = 28'h0, hi = 28'h0;
  logic [27:0] bad_lba = 28'h0;
  logic [15:0] req_cyl_i = 16'h0;
  logic [3:0] req_head_i = 4'h0;
  logic cache_wr_i = 1'h0, media_ack_i = 1'h0, bad_en = 1'h0, fault_en = 1'h0;
  logic busy_o, done_o, cache_full_o, media_wr_o, media_fault_i, media_bad_i;
  logic [7:0] status_o, error_o, media_data_o;
  logic [27:0] cur_lba_o, media_lba_o;
  int miscompares = 0, cmp_count = 0, wr_cnt = 0, bad_wr = 0;
  tfc_if bus ();
  tfc_host u_tfc_host (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .req_i(req_i),
    .req_fmt_i(req_fmt_i), .req_lba_i(req_lba_i), .req_addr_i(req_addr_i),
    .req_cyl_i(req_cyl_i), .req_head_i(req_head_i), .busy_o(busy_o), .done_o(done_o),
    .status_o(status_o), .error_o(error_o), .cur_lba_o(cur_lba_o), .bus(bus));
  tfc_device u_tfc_device (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .bus(bus),
    .cache_wr_i(cache_wr_i), .cache_lba_i(cache_lba_i), .cache_full_o(cache_full_o),
    .media_wr_o(media_wr_o), .media_lba_o(media_lba_o), .media_data_o(media_data_o),
    .media_ack_i(media_ack_i), .media_bad_i(media_bad_i), .media_fault_i(media_fault_i));
  tfc_props u_tfc_props (.core_clk_i, .sys_rst_i, .cmd_valid(bus.cmd_valid),
    .cmd_op(bus.cmd_op), .lba_low(bus.lba_low), .lba_mid(bus.lba_mid),
    .lba_high(bus.lba_high), .dev_reg(bus.dev_reg), .ret_low(bus.ret_low),
    .ret_mid(bus.ret_mid), .ret_high(bus.ret_high), .ret_dev(bus.ret_dev),
    .command_status_flags(bus.command_status_flags),
    .command_error_flags(bus.command_error_flags), .done(bus.done));
  always #2.5 core_clk_i = ~core_clk_i;
  // slow media: acks every other cycle, so the device must wait on it
  always @(negedge core_clk_i) media_ack_i <= media_wr_o && !media_ack_i;
  assign media_fault_i = media_ack_i && fault_en;
  // media marks one chosen sector bad while enabled
  assign media_bad_i = bad_en && media_lba_o == bad_lba;
  // log accepted sector writes; outside lo..hi, nonzero or on a bad sector is bad
  always @(posedge core_clk_i) begin
    if (media_wr_o && media_ack_i) begin
      wr_cnt++;
      if (media_lba_o < lo || media_lba_o > hi || media_data_o !== 8'h00 || media_bad_i) bad_wr++;
    end
  end
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      miscompares++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one host request, bounded wait for its end
  task automatic run(logic fmt, logic lba, logic [27:0] a, logic [27:0] l, logic [27:0] h);
    req_fmt_i = fmt;
    req_lba_i = lba;
    req_addr_i = a;
    lo = l;
    hi = h;
    wr_cnt = 0;
    bad_wr = 0;
    req_i = 1'h1;
    @(negedge core_clk_i);
    req_i = 1'h0;
    chk("host_busy", 1'h1, busy_o);
    for (int i = 0; i < 3000 && done_o !== 1'h1; i++) @(negedge core_clk_i);
    if (done_o !== 1'h1) begin
      miscompares++;
      test_done();
    end
    @(negedge core_clk_i);
  endtask
  task automatic chk_ok(int n);
    chk("writes", n, wr_cnt);
    chk("bad_writes", 0, bad_wr);
    chk("error", 8'h00, error_o);
    chk("busy_err", 2'h0, {status_o[7], status_o[0]});
  endtask
  task automatic t_flush();
    for (int i = 0; i < 8; i++) begin
      cache_wr_i = 1'h1;
      cache_lba_i = 28'h0000100 + 28'(i);
      @(negedge core_clk_i);
    end
    cache_wr_i = 1'h0;
    chk("cache_full", 1'h1, cache_full_o);
    run(1'h0, 1'h1, 28'h0, 28'h0000100, 28'h0000107);
    chk_ok(8);
    chk("cache_full", 1'h0, cache_full_o);
    run(1'h0, 1'h1, 28'h0, 28'h1, 28'h0);
    chk_ok(0);
  endtask
  // top track of the block range
  task automatic t_fmt_lba();
    run(1'h1, 1'h1, 28'h00FFFF5, 28'h00FFFF0, 28'h00FFFFF);
    chk_ok(16);
    chk("cur_lba", 24'h00FFFF, cur_lba_o[27:4]);
    // last sector of the track is bad: skipped, and the format still ends
    bad_lba = 28'h000002F;
    bad_en = 1'h1;
    run(1'h1, 1'h1, 28'h0000023, 28'h0000020, 28'h000002F);
    bad_en = 1'h0;
    chk_ok(15);
  endtask
  // last cylinder, last head
  task automatic t_fmt_chs();
    req_cyl_i = 16'h03FF;
    req_head_i = 4'hF;
    run(1'h1, 1'h0, 28'h0, 28'h003FFF0, 28'h003FFFF);
    chk_ok(16);
    chk("cur_chs", 28'h0, cur_lba_o);
  endtask
  // address only legal if bits 24-27 were dropped
  task automatic t_bad();
    run(1'h1, 1'h1, 28'h1000000, 28'h1, 28'h0);
    chk("writes", 0, wr_cnt);
    chk("idnf", 8'h10, error_o);
    chk("err_bits", 2'h1, {status_o[7], status_o[0]});
  endtask
  task automatic t_fault();
    fault_en = 1'h1;
    run(1'h1, 1'h1, 28'h0000010, 28'h0000010, 28'h000001F);
    fault_en = 1'h0;
    chk("abort", 8'h04, error_o);
    chk("err_bits", 2'h1, {status_o[7], status_o[0]});
    chk("writes", 1, wr_cnt);
    chk("host_busy", 1'h0, busy_o);
    // a faulted flush keeps its block; the next flush writes it
    cache_wr_i = 1'h1;
    cache_lba_i = 28'h0000200;
    @(negedge core_clk_i);
    cache_wr_i = 1'h0;
    fault_en = 1'h1;
    run(1'h0, 1'h1, 28'h0, 28'h0000200, 28'h0000200);
    fault_en = 1'h0;
    chk("flush_abort", 8'h04, error_o);
    run(1'h0, 1'h1, 28'h0, 28'h0000200, 28'h0000200);
    chk_ok(1);
  endtask
  initial begin
    repeat (6) @(negedge core_clk_i);
    sys_rst_i = 1'h0;
    @(negedge core_clk_i);
    t_flush();
    t_fmt_lba();
    t_fmt_chs();
    t_bad();
    t_fault();
    test_done();
  end
endmodule
